// ### timer_unit_pkg.sv
// Purpose: Shared constants of the five-channel down-counting timer unit.
// Assumes: Byte addresses on a 32-bit register port, one register per aligned word.
// Notes: Narrow registers sit in the low bits of the word; upper bits read as zero.
package timer_unit_pkg;

    localparam int NUM_CH = 5;
    localparam int NUM_PIN_CH = 3;

    // Register byte addresses.
    localparam logic [31:0] ADDR_PIN_OUTPUT_CONTROL = 32'hffd80000;
    localparam logic [31:0] ADDR_START_CONTROL_CH0_2 = 32'hffd80004;
    localparam logic [31:0] ADDR_START_CONTROL_CH3_4 = 32'hfe100004;
    localparam logic [31:0] ADDR_CAPTURE_VALUE_CH2 = 32'hffd8002c;
    localparam logic [31:0] ADDR_IRQ_STATUS = 32'hffd80030;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'hffd80034;
    localparam logic [31:0] ADDR_RELOAD [NUM_CH] = '{32'hffd80008, 32'hffd80014, 32'hffd80020,
                                                     32'hfe100008, 32'hfe100014};
    localparam logic [31:0] ADDR_COUNTER [NUM_CH] = '{32'hffd8000c, 32'hffd80018, 32'hffd80024,
                                                      32'hfe10000c, 32'hfe100018};
    localparam logic [31:0] ADDR_CONTROL [NUM_CH] = '{32'hffd80010, 32'hffd8001c, 32'hffd80028,
                                                      32'hfe100010, 32'hfe10001c};

    // Reset values.
    localparam logic [7:0] RESET_PIN_OUTPUT_CONTROL = 8'h00;
    localparam logic [7:0] RESET_START = 8'h00;
    localparam logic [31:0] RESET_RELOAD = 32'h0fffffff;
    localparam logic [31:0] RESET_COUNTER = 32'h0fffffff;
    localparam logic [15:0] RESET_CONTROL = 16'h0000;
    localparam logic [5:0] RESET_IRQ = 6'h00;

    // Implemented bit masks; all other bits read zero and ignore writes.
    localparam logic [7:0] MASK_PIN_OUTPUT_CONTROL = 8'h01;
    localparam logic [7:0] MASK_START_CH0_2 = 8'h07;
    localparam logic [7:0] MASK_START_CH3_4 = 8'h03;
    localparam logic [15:0] MASK_CONTROL [NUM_CH] = '{16'h013f, 16'h013f, 16'h03ff, 16'h0127, 16'h0127};

    // Control register field positions.
    localparam int CTL_CLK_SEL_LSB = 0;
    localparam int CTL_EDGE_LSB = 3;
    localparam int CTL_UNDERFLOW_IE = 5;
    localparam int CTL_CAPTURE_EN_LSB = 6;
    localparam int CTL_UNDERFLOW_FLAG = 8;
    localparam int CTL_CAPTURE_FLAG = 9;
    localparam int PIN_OUTPUT_SELECT_BIT = 0;

    // Interrupt status layout: bits 4..0 underflow per channel, bit 5 capture.
    localparam int IRQ_CAPTURE_BIT = 5;

    // Count clock selections.
    localparam logic [2:0] CLK_SEL_RTC = 3'h6;
    localparam logic [2:0] CLK_SEL_PIN = 3'h7;
    localparam int NUM_DIV = 5;
    localparam int PRESCALE_BITS = 10;

endpackage : timer_unit_pkg

// ### timer_unit.sv
// Purpose: Five-channel 32-bit auto-reload down-counting timer with start, pin and capture control.
// Assumes: clk is the peripheral clock; manual reset and standby levels come from clk-domain logic.
// Notes: The pin and the real-time-clock output clock are asynchronous and are synchronised here.
`timescale 1ns/1ps
module timer_unit #(
    parameter int NUM_CH = timer_unit_pkg::NUM_CH
) (
    // Clock and power-on reset.
    input wire logic clk,
    input wire logic rst,
    // Power state from the system controller.
    input wire logic manual_rst,
    input wire logic standby,
    input wire logic module_standby,
    // Register port.
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Shared timer pin.
    input wire logic shared_timer_pin_in,
    output logic shared_timer_pin_out,
    output logic shared_timer_pin_oe,
    // Real-time-clock output clock.
    input wire logic rtc_output_clock,
    // Channel run state and interrupt.
    output logic [4:0] run_enable,
    output logic irq
);

    // The register map and the interrupt status layout are fixed at five channels.
    if (NUM_CH != timer_unit_pkg::NUM_CH) begin : g_bad_num_ch
        $error("timer_unit serves exactly five channels");
    end
    // The slowest internal tick needs two more prescaler bits per divider step.
    if (timer_unit_pkg::PRESCALE_BITS < 2 * timer_unit_pkg::NUM_DIV) begin : g_bad_prescale
        $error("timer_unit prescaler too narrow for its divider taps");
    end
    if (timer_unit_pkg::NUM_PIN_CH > NUM_CH) begin : g_bad_pin_ch
        $error("timer_unit has more pin channels than channels");
    end

    // Input synchronisers; the third stage only feeds edge detection.
    logic pin_s1_q, pin_s2_q, pin_s3_q;
    logic rtc_s1_q, rtc_s2_q, rtc_s3_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
            rtc_s1_q <= 1'b0;
            rtc_s2_q <= 1'b0;
            rtc_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= shared_timer_pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            rtc_s1_q <= rtc_output_clock;
            rtc_s2_q <= rtc_s1_q;
            rtc_s3_q <= rtc_s2_q;
        end
    end

    logic pin_rise, pin_fall, rtc_tick;
    assign pin_rise = pin_s2_q & ~pin_s3_q;
    assign pin_fall = ~pin_s2_q & pin_s3_q;
    assign rtc_tick = rtc_s2_q & ~rtc_s3_q;

    // The peripheral clock is considered stopped for the unit in either standby state.
    logic unit_clock_on;
    assign unit_clock_on = ~standby & ~module_standby;

    // Prescaler for the internal divide-by-4 to divide-by-1024 ticks.
    logic [timer_unit_pkg::PRESCALE_BITS-1:0] presc_q, presc_d;
    logic [timer_unit_pkg::NUM_DIV-1:0] div_tick;

    always_comb begin
        presc_d = presc_q;
        if (unit_clock_on) begin
            presc_d = presc_q + 10'h001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_d;
        end
    end

    genvar gd;
    generate
        for (gd = 0; gd < timer_unit_pkg::NUM_DIV; gd++) begin : g_div
            assign div_tick[gd] = unit_clock_on & (&presc_q[2*gd+1:0]);
        end
    endgenerate

    // Register state.
    logic [7:0] pin_ctl_q, pin_ctl_d;
    logic [7:0] start02_q, start02_d;
    logic [7:0] start34_q, start34_d;
    logic [31:0] reload_q [NUM_CH];
    logic [31:0] reload_d [NUM_CH];
    logic [31:0] count_q [NUM_CH];
    logic [31:0] count_d [NUM_CH];
    logic [15:0] ctrl_q [NUM_CH];
    logic [15:0] ctrl_d [NUM_CH];
    logic [5:0] irq_status_q, irq_status_d;
    logic [5:0] irq_mask_q, irq_mask_d;
    logic [31:0] capture_q, capture_d;
    logic [31:0] rdata_q, rdata_d;

    logic pin_is_output;
    assign pin_is_output = pin_ctl_q[timer_unit_pkg::PIN_OUTPUT_SELECT_BIT];

    // Per-channel count tick, rtc selection and underflow.
    logic [NUM_CH-1:0] tick, sel_rtc, underflow, running;
    // A counter write in the same cycle as a plain tick keeps the written value.
    logic [NUM_CH-1:0] count_wr;
    logic capture_event;

    genvar gc;
    generate
        for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
            logic [2:0] clk_sel;
            logic [1:0] edge_sel;
            logic pin_edge;
            logic raw_tick;
            assign clk_sel = ctrl_q[gc][timer_unit_pkg::CTL_CLK_SEL_LSB +: 3];
            assign edge_sel = ctrl_q[gc][timer_unit_pkg::CTL_EDGE_LSB +: 2];
            assign pin_edge = ~pin_is_output & (edge_sel == 2'h0 ? pin_rise :
                              edge_sel == 2'h1 ? pin_fall : (pin_rise | pin_fall));
            if (gc < timer_unit_pkg::NUM_PIN_CH) begin : g_full
                assign sel_rtc[gc] = (clk_sel == timer_unit_pkg::CLK_SEL_RTC);
                assign raw_tick = (clk_sel == timer_unit_pkg::CLK_SEL_RTC) ? (rtc_tick & ~standby) :
                                  (clk_sel == timer_unit_pkg::CLK_SEL_PIN) ? (pin_edge & unit_clock_on) :
                                  (clk_sel < 3'h5) ? div_tick[clk_sel] : 1'b0;
                assign running[gc] = start02_q[gc];
            end else begin : g_internal
                assign sel_rtc[gc] = 1'b0;
                assign raw_tick = (clk_sel < 3'h5) ? div_tick[clk_sel] : 1'b0;
                assign running[gc] = start34_q[gc-timer_unit_pkg::NUM_PIN_CH];
            end
            assign tick[gc] = running[gc] & raw_tick;
            assign count_wr[gc] = wr & (addr == timer_unit_pkg::ADDR_COUNTER[gc]);
            assign underflow[gc] = tick[gc] & (count_q[gc] == 32'h00000000);
        end
    endgenerate

    // Capture on channel 2 uses the counter's pin edge while capture is enabled.
    assign capture_event = (ctrl_q[2][timer_unit_pkg::CTL_CAPTURE_EN_LSB +: 2] != 2'h0) & g_ch[2].pin_edge
                           & unit_clock_on;

    assign run_enable = running;

    // Register writes, counting and power-state effects.
    always_comb begin
        logic [15:0] ctl_w;
        ctl_w = '0;
        pin_ctl_d = pin_ctl_q;
        start02_d = start02_q;
        start34_d = start34_q;
        irq_status_d = irq_status_q;
        irq_mask_d = irq_mask_q;
        capture_d = capture_q;
        for (int c = 0; c < NUM_CH; c++) begin
            reload_d[c] = reload_q[c];
            count_d[c] = count_q[c];
            ctrl_d[c] = ctrl_q[c];
        end

        if (wr) begin
            if (addr == timer_unit_pkg::ADDR_PIN_OUTPUT_CONTROL) begin
                pin_ctl_d = wdata[7:0] & timer_unit_pkg::MASK_PIN_OUTPUT_CONTROL;
            end
            if (addr == timer_unit_pkg::ADDR_START_CONTROL_CH0_2) begin
                start02_d = wdata[7:0] & timer_unit_pkg::MASK_START_CH0_2;
            end
            if (addr == timer_unit_pkg::ADDR_START_CONTROL_CH3_4) begin
                start34_d = wdata[7:0] & timer_unit_pkg::MASK_START_CH3_4;
            end
            if (addr == timer_unit_pkg::ADDR_IRQ_MASK) begin
                irq_mask_d = wdata[5:0];
            end
            if (addr == timer_unit_pkg::ADDR_IRQ_STATUS) begin
                irq_status_d = irq_status_q & ~wdata[5:0];
            end
            for (int c = 0; c < NUM_CH; c++) begin
                if (addr == timer_unit_pkg::ADDR_RELOAD[c]) begin
                    reload_d[c] = wdata;
                end
                if (addr == timer_unit_pkg::ADDR_COUNTER[c]) begin
                    count_d[c] = wdata;
                end
                if (addr == timer_unit_pkg::ADDR_CONTROL[c]) begin
                    // Flags clear on a zero write and are unchanged by a one.
                    ctl_w = wdata[15:0] & timer_unit_pkg::MASK_CONTROL[c];
                    ctl_w[timer_unit_pkg::CTL_UNDERFLOW_FLAG] = ctrl_q[c][timer_unit_pkg::CTL_UNDERFLOW_FLAG]
                        & wdata[timer_unit_pkg::CTL_UNDERFLOW_FLAG];
                    ctl_w[timer_unit_pkg::CTL_CAPTURE_FLAG] = ctrl_q[c][timer_unit_pkg::CTL_CAPTURE_FLAG]
                        & wdata[timer_unit_pkg::CTL_CAPTURE_FLAG] & timer_unit_pkg::MASK_CONTROL[c][9];
                    ctrl_d[c] = ctl_w;
                end
            end
        end

        // Counting comes after the bus so a set from hardware wins over a clear.
        for (int c = 0; c < NUM_CH; c++) begin
            if (underflow[c]) begin
                count_d[c] = reload_q[c];
                ctrl_d[c][timer_unit_pkg::CTL_UNDERFLOW_FLAG] = 1'b1;
                irq_status_d[c] = 1'b1;
            end else if (tick[c] && !count_wr[c]) begin
                count_d[c] = count_q[c] - 32'h00000001;
            end
        end

        if (capture_event) begin
            capture_d = count_q[2];
            ctrl_d[2][timer_unit_pkg::CTL_CAPTURE_FLAG] = 1'b1;
            irq_status_d[timer_unit_pkg::IRQ_CAPTURE_BIT] = 1'b1;
        end

        if (module_standby) begin
            for (int c = 0; c < timer_unit_pkg::NUM_PIN_CH; c++) begin
                if (!sel_rtc[c]) begin
                    start02_d[c] = 1'b0;
                end
            end
        end

        // Full standby comes after module standby so it overrides the rtc exception.
        // standby start clear
        if (standby) begin
            start02_d = timer_unit_pkg::RESET_START;
        end

        if (manual_rst) begin
            pin_ctl_d = timer_unit_pkg::RESET_PIN_OUTPUT_CONTROL;
            start02_d = timer_unit_pkg::RESET_START;
            irq_status_d[timer_unit_pkg::NUM_PIN_CH-1:0] = 3'h0;
            irq_status_d[timer_unit_pkg::IRQ_CAPTURE_BIT] = 1'b0;
            for (int c = 0; c < timer_unit_pkg::NUM_PIN_CH; c++) begin
                reload_d[c] = timer_unit_pkg::RESET_RELOAD;
                count_d[c] = timer_unit_pkg::RESET_COUNTER;
                ctrl_d[c] = timer_unit_pkg::RESET_CONTROL;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_ctl_q <= timer_unit_pkg::RESET_PIN_OUTPUT_CONTROL;
            start02_q <= timer_unit_pkg::RESET_START;
            start34_q <= timer_unit_pkg::RESET_START;
            irq_status_q <= timer_unit_pkg::RESET_IRQ;
            irq_mask_q <= timer_unit_pkg::RESET_IRQ;
            for (int c = 0; c < NUM_CH; c++) begin
                reload_q[c] <= timer_unit_pkg::RESET_RELOAD;
                count_q[c] <= timer_unit_pkg::RESET_COUNTER;
                ctrl_q[c] <= timer_unit_pkg::RESET_CONTROL;
            end
        end else begin
            pin_ctl_q <= pin_ctl_d;
            start02_q <= start02_d;
            start34_q <= start34_d;
            irq_status_q <= irq_status_d;
            irq_mask_q <= irq_mask_d;
            for (int c = 0; c < NUM_CH; c++) begin
                reload_q[c] <= reload_d[c];
                count_q[c] <= count_d[c];
                ctrl_q[c] <= ctrl_d[c];
            end
        end
    end

    // No reset here on purpose: software must not rely on the value before a capture.
    // capture never reset
    always_ff @(posedge clk) begin
        capture_q <= capture_d;
    end

    // Read data stand for exactly the cycle after the strobe; unmapped reads return zero.
    always_comb begin
        rdata_d = 32'h00000000;
        if (rd) begin
            if (addr == timer_unit_pkg::ADDR_PIN_OUTPUT_CONTROL) begin
                rdata_d = {24'h000000, pin_ctl_q};
            end
            if (addr == timer_unit_pkg::ADDR_START_CONTROL_CH0_2) begin
                rdata_d = {24'h000000, start02_q};
            end
            if (addr == timer_unit_pkg::ADDR_START_CONTROL_CH3_4) begin
                rdata_d = {24'h000000, start34_q};
            end
            if (addr == timer_unit_pkg::ADDR_CAPTURE_VALUE_CH2) begin
                rdata_d = capture_q;
            end
            if (addr == timer_unit_pkg::ADDR_IRQ_STATUS) begin
                rdata_d = {26'h0000000, irq_status_q};
            end
            if (addr == timer_unit_pkg::ADDR_IRQ_MASK) begin
                rdata_d = {26'h0000000, irq_mask_q};
            end
            for (int c = 0; c < NUM_CH; c++) begin
                if (addr == timer_unit_pkg::ADDR_RELOAD[c]) begin
                    rdata_d = reload_q[c];
                end
                if (addr == timer_unit_pkg::ADDR_COUNTER[c]) begin
                    rdata_d = count_q[c];
                end
                if (addr == timer_unit_pkg::ADDR_CONTROL[c]) begin
                    rdata_d = {16'h0000, ctrl_q[c]};
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;
    assign irq = |(irq_status_q & irq_mask_q);

    assign shared_timer_pin_oe = pin_is_output;
    // The rtc clock leaves through the synchroniser, so the pin lags it by two clocks.
    // low in standby
    assign shared_timer_pin_out = pin_is_output & ~standby & rtc_s2_q;

endmodule : timer_unit

// ### timer_unit_properties.sv
// Purpose: Port-level properties of the timer unit pin and start control.
// Assumes: One clock domain; rst is the power-on reset.
// Notes: Register state is seen only through the pin, run-enable and read data ports.
`timescale 1ns/1ps
module timer_unit_properties (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Power state.
    input wire logic manual_rst,
    input wire logic standby,
    input wire logic module_standby,
    // Register port.
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    // Pin, rtc clock, run state and interrupt.
    input wire logic shared_timer_pin_in,
    input wire logic shared_timer_pin_out,
    input wire logic shared_timer_pin_oe,
    input wire logic rtc_output_clock,
    input wire logic [4:0] run_enable,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_quiet;
        !manual_rst && !standby && !module_standby;
    endsequence
    sequence s_wr_pin;
        wr && addr == timer_unit_pkg::ADDR_PIN_OUTPUT_CONTROL ##0 s_quiet;
    endsequence
    sequence s_wr_start0;
        wr && addr == timer_unit_pkg::ADDR_START_CONTROL_CH0_2 ##0 s_quiet;
    endsequence
    sequence s_wr_start2;
        wr && addr == timer_unit_pkg::ADDR_START_CONTROL_CH3_4 ##0 s_quiet;
    endsequence

    a_pin_standby_low: assert property (standby && $past(standby) |-> shared_timer_pin_out == 1'b0)
        else $error("pin output high during standby");
    a_pin_input_quiet: assert property (!shared_timer_pin_oe |-> shared_timer_pin_out == 1'b0)
        else $error("pin output active while pin is an input");
    a_pin_select_set: assert property (s_wr_pin |=> shared_timer_pin_oe == $past(wdata[0]))
        else $error("pin enable does not follow written select bit");
    a_pin_manual_clear: assert property (manual_rst && !wr |=> !shared_timer_pin_oe)
        else $error("pin select survived manual reset");
    a_pin_standby_hold: assert property (standby && !manual_rst && !wr |=> $stable(shared_timer_pin_oe))
        else $error("pin select changed in standby");
    a_start_standby_clear: assert property (standby && !wr |=> run_enable[2:0] == 3'h0)
        else $error("channel 0 to 2 start bits not cleared by standby");
    a_start_manual_clear: assert property (manual_rst && !wr |=> run_enable[2:0] == 3'h0
        && $stable(run_enable[4:3]))
        else $error("start bits wrong after manual reset");
    a_start_write_low: assert property (s_wr_start0 |=> run_enable[2:0] == $past(wdata[2:0]))
        else $error("channel 0 to 2 run state does not follow write");
    a_start_write_high: assert property (s_wr_start2 |=> run_enable[4:3] == $past(wdata[1:0]))
        else $error("channel 3 and 4 run state does not follow write");
    a_start_idle_hold: assert property (!wr ##0 s_quiet |=> $stable(run_enable))
        else $error("run state changed without a write");
    a_unused_pin_read: assert property (rd && addr == timer_unit_pkg::ADDR_PIN_OUTPUT_CONTROL
        |=> rdata[31:1] == 31'h0)
        else $error("unused pin control bits read nonzero");
    a_unused_start_read: assert property (rd && addr == timer_unit_pkg::ADDR_START_CONTROL_CH0_2
        |=> rdata[31:3] == 29'h0)
        else $error("unused start bits read nonzero");
endmodule : timer_unit_properties

// ### timer_pin_partner.sv
// Purpose: Far side of the shared timer pin and the free-running rtc output clock.
// Assumes: The rtc clock is unrelated in phase to the peripheral clock.
// Notes: The rtc clock is much faster than a real one to keep the run short.
`timescale 1ns/1ps
module timer_pin_partner #(
    parameter int RTC_HALF_NS = 60
) (
    // Device side of the pin.
    input wire logic pin_out,
    input wire logic pin_oe,
    // Level offered by the external source.
    input wire logic ext_level,
    // Resolved pin level and rtc clock.
    output logic pin_level,
    output logic rtc_output_clock
);
    assign pin_level = pin_oe ? pin_out : ext_level;

    initial begin
        rtc_output_clock = 1'b0;
        #3;
        forever #(RTC_HALF_NS) rtc_output_clock = ~rtc_output_clock;
    end
endmodule : timer_pin_partner

// ### timer_unit_test.sv
// Purpose: Self-checking bench for the timer unit registers, start and pin control.
// Assumes: Register port with one-cycle read latency; tests run one after another.
// Notes: Counter values after free counting are checked by range, the prescaler phase is unknown.
`timescale 1ns/1ps
module timer_unit_test;
    localparam logic [31:0] PIN = timer_unit_pkg::ADDR_PIN_OUTPUT_CONTROL;
    localparam logic [31:0] ST0 = timer_unit_pkg::ADDR_START_CONTROL_CH0_2;
    localparam logic [31:0] ST2 = timer_unit_pkg::ADDR_START_CONTROL_CH3_4;
    localparam logic [31:0] ALL1 = 32'h0fffffff;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic manual_rst = 1'b0;
    logic standby = 1'b0;
    logic module_standby = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ext_level = 1'b0;
    logic [31:0] rdata;
    logic pin_level, pin_out, pin_oe, rtc_clk, irq;
    logic [4:0] run_enable;
    int miscompares = 0;
    int n_tests = 0;

    timer_unit DUT (.clk(clk), .rst(rst), .manual_rst(manual_rst), .standby(standby),
        .module_standby(module_standby), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .shared_timer_pin_in(pin_level), .shared_timer_pin_out(pin_out), .shared_timer_pin_oe(pin_oe),
        .rtc_output_clock(rtc_clk), .run_enable(run_enable), .irq(irq));
    timer_pin_partner far_side (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
        .pin_level(pin_level), .rtc_output_clock(rtc_clk));

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Leaves rdata valid for the caller until the next rising edge.
    task automatic rd_reg(input logic [31:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
    endtask : rd_reg

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        rd_reg(a);
        check(rdata, exp);
    endtask : rd_chk

    task automatic summarize;
        $display("tests=%0d miscompares=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    initial begin
        #200000;
        miscompares++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd_chk(PIN, 32'h0);
        rd_chk(ST0, 32'h0);
        rd_chk(ST2, 32'h0);
        for (int i = 0; i < 5; i++) begin
            rd_chk(timer_unit_pkg::ADDR_RELOAD[i], ALL1);
            rd_chk(timer_unit_pkg::ADDR_COUNTER[i], ALL1);
            rd_chk(timer_unit_pkg::ADDR_CONTROL[i], 32'h0);
        end
        $display("test reset values done");
        wr_reg(PIN, 32'hff);
        rd_chk(PIN, 32'h1);
        check({31'h0, pin_oe}, 32'h1);
        wr_reg(ST0, 32'hff);
        rd_chk(ST0, 32'h7);
        check({27'h0, run_enable}, 32'h7);
        wr_reg(ST2, 32'hff);
        rd_chk(ST2, 32'h3);
        check({27'h0, run_enable}, 32'h1f);
        rd_chk(32'hffd80040, 32'h0);
        @(posedge rtc_clk);
        repeat (6) @(posedge clk);
        #1;
        check({31'h0, pin_out}, 32'h1);
        wr_reg(ST0, 32'h0);
        wr_reg(ST2, 32'h0);
        $display("test unused bits done");
        wr_reg(timer_unit_pkg::ADDR_RELOAD[3], 32'h0abc);
        wr_reg(ST2, 32'h2);
        wr_reg(ST0, 32'h5);
        wr_reg(timer_unit_pkg::ADDR_COUNTER[0], 32'h77);
        @(posedge clk);
        manual_rst <= 1'b1;
        @(posedge clk);
        manual_rst <= 1'b0;
        rd_chk(PIN, 32'h0);
        rd_chk(ST0, 32'h0);
        rd_chk(timer_unit_pkg::ADDR_COUNTER[0], ALL1);
        rd_chk(timer_unit_pkg::ADDR_RELOAD[3], 32'h0abc);
        rd_chk(ST2, 32'h2);
        wr_reg(ST2, 32'h0);
        $display("test manual reset done");
        wr_reg(PIN, 32'h1);
        wr_reg(ST0, 32'h7);
        @(posedge clk);
        standby <= 1'b1;
        repeat (20) @(posedge clk);
        #1;
        check({28'h0, run_enable[2:0], pin_out}, 32'h0);
        @(posedge clk);
        standby <= 1'b0;
        rd_chk(PIN, 32'h1);
        rd_chk(ST0, 32'h0);
        wr_reg(PIN, 32'h0);
        $display("test standby done");
        wr_reg(timer_unit_pkg::ADDR_IRQ_MASK, 32'h0);
        wr_reg(timer_unit_pkg::ADDR_RELOAD[3], 32'h5);
        wr_reg(timer_unit_pkg::ADDR_COUNTER[3], 32'h1);
        wr_reg(ST2, 32'h1);
        repeat (40) @(posedge clk);
        wr_reg(ST2, 32'h0);
        rd_chk(timer_unit_pkg::ADDR_CONTROL[3], 32'h100);
        rd_reg(timer_unit_pkg::ADDR_COUNTER[3]);
        check({31'h0, rdata <= 32'h5}, 32'h1);
        rd_chk(timer_unit_pkg::ADDR_IRQ_STATUS, 32'h8);
        check({31'h0, irq}, 32'h0);
        wr_reg(timer_unit_pkg::ADDR_IRQ_MASK, 32'h8);
        rd_chk(timer_unit_pkg::ADDR_IRQ_MASK, 32'h8);
        check({31'h0, irq}, 32'h1);
        wr_reg(timer_unit_pkg::ADDR_IRQ_STATUS, 32'h8);
        rd_chk(timer_unit_pkg::ADDR_IRQ_STATUS, 32'h0);
        check({31'h0, irq}, 32'h0);
        $display("test underflow done");
        wr_reg(timer_unit_pkg::ADDR_COUNTER[3], 32'h1234);
        repeat (20) @(posedge clk);
        rd_chk(timer_unit_pkg::ADDR_COUNTER[3], 32'h1234);
        wr_reg(ST2, 32'h1);
        repeat (20) @(posedge clk);
        wr_reg(ST2, 32'h0);
        rd_reg(timer_unit_pkg::ADDR_COUNTER[3]);
        check({31'h0, rdata < 32'h1234 && rdata > 32'h1220}, 32'h1);
        $display("test hold and resume done");
        wr_reg(timer_unit_pkg::ADDR_CONTROL[0], {29'h0, timer_unit_pkg::CLK_SEL_RTC});
        wr_reg(timer_unit_pkg::ADDR_COUNTER[0], 32'h100);
        wr_reg(ST0, 32'h3);
        @(posedge clk);
        module_standby <= 1'b1;
        repeat (40) @(posedge clk);
        #1;
        check({29'h0, run_enable[2:0]}, 32'h1);
        @(posedge clk);
        module_standby <= 1'b0;
        wr_reg(ST0, 32'h0);
        rd_reg(timer_unit_pkg::ADDR_COUNTER[0]);
        check({31'h0, rdata < 32'h100}, 32'h1);
        $display("test module standby done");
        wr_reg(timer_unit_pkg::ADDR_CONTROL[1], {29'h0, timer_unit_pkg::CLK_SEL_PIN});
        wr_reg(timer_unit_pkg::ADDR_COUNTER[1], 32'h10);
        wr_reg(timer_unit_pkg::ADDR_CONTROL[2], 32'h40);
        wr_reg(timer_unit_pkg::ADDR_COUNTER[2], 32'h55);
        wr_reg(ST0, 32'h2);
        // Three rising pin edges: each is one count of channel 1 and one capture of stopped channel 2.
        repeat (3) begin
            ext_level <= 1'b1;
            repeat (4) @(posedge clk);
            ext_level <= 1'b0;
            repeat (4) @(posedge clk);
        end
        wr_reg(ST0, 32'h0);
        rd_chk(timer_unit_pkg::ADDR_COUNTER[1], 32'hd);
        rd_chk(timer_unit_pkg::ADDR_CAPTURE_VALUE_CH2, 32'h55);
        rd_chk(timer_unit_pkg::ADDR_CONTROL[2], 32'h240);
        wr_reg(timer_unit_pkg::ADDR_CAPTURE_VALUE_CH2, 32'h0);
        rd_chk(timer_unit_pkg::ADDR_CAPTURE_VALUE_CH2, 32'h55);
        $display("test pin input and capture done");
        summarize();
    end
endmodule : timer_unit_test

bind timer_unit timer_unit_properties u_props (.clk(clk), .rst(rst), .manual_rst(manual_rst),
    .standby(standby), .module_standby(module_standby), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .shared_timer_pin_in(shared_timer_pin_in), .shared_timer_pin_out(shared_timer_pin_out),
    .shared_timer_pin_oe(shared_timer_pin_oe), .rtc_output_clock(rtc_output_clock),
    .run_enable(run_enable), .irq(irq));
